// ===== bench/bbpmd_tb.sv
// self-checking bench for the byte/bit/pointer transfer_op unit
`timescale 1ns/100ps
module testbench;
   import bbpmd_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic start = 1'b0;
   logic carry = 1'b0;
   logic [1:0] bank = 2'h0;
   logic [7:0] opcode = 8'h00;
   logic [7:0] byte2 = 8'h00;
   logic [7:0] byte3 = 8'h00;
   logic [7:0] acc = 8'h00;
   logic [7:0] mem [256];
   logic [7:0] rd_data, rd_addr, wr_addr, wr_data;
   logic ready, hit, rd_en, wr_en, carry_we, carry_new, carry_got;
   logic [1:0] len;
   logic [15:0] pointer;
   int error_cnt = 0;
   int check_count = 0;
   int wr_cnt = 0;
   int carry_cnt = 0;
   int cyc = 0;

   bbpmd_core dut (.CLK_I(clk), .RESETN_I(resetn), .START_I(start), .OPCODE_I(opcode),
      .BYTE2_I(byte2), .BYTE3_I(byte3), .ACC_I(acc), .CARRY_I(carry), .BANK_I(bank),
      .RD_DATA_I(rd_data), .READY_O(ready), .DECODE_HIT_O(hit), .LENGTH_O(len),
      .RD_EN_O(rd_en), .RD_ADDR_O(rd_addr), .WR_EN_O(wr_en), .WR_ADDR_O(wr_addr),
      .WR_DATA_O(wr_data), .CARRY_WE_O(carry_we), .CARRY_O(carry_new), .POINTER_O(pointer));

   // memory answers reads in the same cycle and commits writes on the closing edge
   // reads without the strobe give zero, so a missing read strobe breaks the results
   assign rd_data = (rd_en === 1'b1) ? mem[rd_addr] : 8'h00;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wr_en === 1'b1) begin
         mem[wr_addr] <= wr_data;
         wr_cnt <= wr_cnt + 1;
      end
      if (carry_we === 1'b1) begin
         carry_got <= carry_new;
         carry_cnt <= carry_cnt + 1;
      end
      // a hang is cut short well beyond the roughly 80 cycles the tests need
      if (cyc == 4000) begin
         error_cnt++;
         give_verdict();
      end
   end

   initial begin
      forever #20 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // issues one instruction, checks length and step count, lets its writes land
   task automatic run(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3,
         input int ncyc, input logic [1:0] nlen);
      int k;
      opcode = op;
      byte2 = b2;
      byte3 = b3;
      start = 1'b1;
      #1;
      check(hit, 1'b1);
      check(len, nlen);
      @(posedge clk);
      #1 start = 1'b0;
      for (k = 1; k < ncyc; k++) begin
         check(ready, 1'b0);
         @(posedge clk);
         #1;
      end
      check(ready, 1'b1);
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic t_dir_ind();
      int i;
      bank = 2'h2;
      for (i = 0; i < 2; i++) begin
         mem[16 + i] = 8'h40 + 8'(i);
         mem[8'h40 + i] = 8'hA0 + 8'(i);
         run(OPC_DIR_IND | 8'(i), 8'h30, 8'h00, 2, LEN_TWO);
         check(mem[8'h30], 8'hA0 + i);
      end
   endtask

   task automatic t_dir_imm();
      run(OPC_DIR_IMM, 8'h55, 8'h3C, 2, LEN_THREE);
      check(mem[8'h55], 8'h3C);
   endtask

   task automatic t_ind();
      int i;
      bank = 2'h1;
      for (i = 0; i < 2; i++) begin
         mem[8 + i] = 8'h60 + 8'(i);
         acc = 8'hC0 + 8'(i);
         run(OPC_IND_ACC | 8'(i), 8'h00, 8'h00, 1, LEN_ONE);
         check(mem[8'h60 + i], 8'hC0 + i);
         run(OPC_IND_IMM | 8'(i), 8'h5A + 8'(i), 8'h00, 1, LEN_TWO);
         check(mem[8'h60 + i], 8'h5A + i);
      end
   endtask

   // one bit in the byte area and one in a register byte
   task automatic t_bits();
      int j, v, n;
      logic [7:0] ba, b, m, old;
      for (j = 0; j < 2; j++) begin
         ba = (j == 0) ? 8'h1B : 8'h92;
         b = ba[7] ? {ba[7:3], 3'h0} : 8'h20 + ba[6:3];
         m = 8'h01 << ba[2:0];
         for (v = 0; v < 2; v++) begin
            mem[b] = v ? m : ~m;
            carry = !v;
            run(OPC_C_BIT, ba, 8'h00, 1, LEN_TWO);
            check(carry_got, v);
            old = 8'h5A ^ m;
            mem[b] = old;
            n = carry_cnt;
            carry = v;
            run(OPC_BIT_C, ba, 8'h00, 2, LEN_TWO);
            check(mem[b], v ? (old | m) : (old & ~m));
            check(carry_cnt, n);
         end
      end
   endtask

   // second instruction taken in the last step of the first, with no idle cycle between
   task automatic t_b2b();
      bank = 2'h0;
      mem[0] = 8'h70;
      acc = 8'h3E;
      opcode = OPC_IND_ACC;
      start = 1'b1;
      @(posedge clk);
      #1;
      check(ready, 1'b1);
      opcode = OPC_DIR_IMM;
      byte2 = 8'h71;
      byte3 = 8'h4D;
      @(posedge clk);
      #1 start = 1'b0;
      check(ready, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      check(mem[8'h70], 8'h3E);
      check(mem[8'h71], 8'h4D);
   endtask

   task automatic t_ptr();
      int n, w;
      n = carry_cnt;
      w = wr_cnt;
      run(OPC_PTR_LD, 8'h12, 8'h34, 2, LEN_THREE);
      check(pointer, 16'h1234);
      run(OPC_PTR_LD, 8'hAB, 8'hCD, 2, LEN_THREE);
      check(pointer, 16'hABCD);
      check(carry_cnt, n);
      check(wr_cnt, w);
      // an unhandled opcode must be ignored
      opcode = 8'hA5;
      start = 1'b1;
      #1;
      check(hit, 1'b0);
      check(len, LEN_NONE);
      @(posedge clk);
      #1 start = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check(wr_cnt, w);
      check(pointer, 16'hABCD);
   endtask

   initial begin
      for (int k = 0; k < 256; k++) mem[k] = 8'h00;
      repeat (12) @(posedge clk);
      #1;
      check(ready, 1'b1);
      check(pointer, 16'h0000);
      resetn = 1'b1;
      @(posedge clk);
      #1;
      t_dir_ind();
      t_dir_imm();
      t_ind();
      t_bits();
      t_b2b();
      t_ptr();
      give_verdict();
   end
endmodule // testbench

// ===== core/bbpmd_addr_map.sv
// address mapping for the index register and the direct bit space
`timescale 1ns/100ps
module bbpmd_addr_map
   import bbpmd_pkg::*;
(
   input wire logic [1:0] bank_i,
   input wire logic index_i,
   input wire logic [7:0] bit_addr_i,
   output logic [7:0] index_addr_o,
   output logic [7:0] bit_byte_addr_o,
   output logic [2:0] bit_pos_o
);
   wire [7:0] low_area_byte;
   wire [7:0] high_area_byte;

   // register zero or one of the active bank, eight registers per bank
   assign index_addr_o = {3'h0, bank_i, 2'h0, index_i};
   assign low_area_byte = BIT_AREA_BASE + {4'h0, bit_addr_i[6:3]};
   assign high_area_byte = {bit_addr_i[7:3], 3'h0};
   assign bit_byte_addr_o = bit_addr_i[BIT_SPLIT] ? high_area_byte : low_area_byte;
   assign bit_pos_o = bit_addr_i[2:0];
endmodule // bbpmd_addr_map

// ===== core/bbpmd_core.sv
// decode and execute of byte, bit and pointer-load transfer_op instructions
// Overview of operation
// - opcode 1000011i moves indirect location to direct address; 2 bytes, 2 cycles.
// - opcode 01110101 writes byte-three constant to byte-two address; 3 bytes, 2 cycles.
// - opcode 10100010 copies the addressed bit into carry; 2 bytes, 1 cycle.
// - every bit transfer has carry at one end, any direct bit at the other.
// - a bit transfer changes only its destination bit, nothing else.
// - pointer load places a 16-bit constant at once; 3 bytes, 2 cycles.
// - second byte goes to the pointer high half, third byte to the low half.
// - pointer load leaves every status flag untouched.
// - index bit selects register zero or one of the active bank.
`timescale 1ns/100ps
module bbpmd_core
   import bbpmd_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic START_I,
   input wire logic [7:0] OPCODE_I,
   input wire logic [7:0] BYTE2_I,
   input wire logic [7:0] BYTE3_I,
   input wire logic [7:0] ACC_I,
   input wire logic CARRY_I,
   input wire logic [1:0] BANK_I,
   input wire logic [7:0] RD_DATA_I,
   output logic READY_O,
   output logic DECODE_HIT_O,
   output logic [1:0] LENGTH_O,
   output logic RD_EN_O,
   output logic [7:0] RD_ADDR_O,
   output logic WR_EN_O,
   output logic [7:0] WR_ADDR_O,
   output logic [7:0] WR_DATA_O,
   output logic CARRY_WE_O,
   output logic CARRY_O,
   output logic [15:0] POINTER_O
);
   bbpmd_state_t state, next_state;
   bbpmd_op_t op;
   logic index_sel;
   logic [7:0] opr1, opr2, acc, ind_ptr, rmw_byte;
   logic carry_in;
   logic [1:0] bank;
   logic [7:0] pointer_high_byte, pointer_low_byte;
   logic wr_en, carry_we, carry_val;
   logic [7:0] wr_addr, wr_data;

   bbpmd_op_t in_op;
   wire step1, step2, last_step, take, is_indirect;
   wire [1:0] op_cycles;
   wire [7:0] index_addr, bit_byte_addr, bit_mask, bit_merged;
   wire [2:0] bit_pos;
   wire next_wr_en, next_carry_we, next_carry_val;
   wire [7:0] next_wr_addr, next_wr_data;

   assign in_op = bbpmd_decode(OPCODE_I);
   assign DECODE_HIT_O = (in_op != OP_NONE);
   assign LENGTH_O = bbpmd_bytes(in_op);
   assign step1 = (state == ST_STEP1);
   assign step2 = (state == ST_STEP2);
   assign op_cycles = bbpmd_cycles(op);
   // ready already in the last step so that instructions run back to back
   assign last_step = (step1 && op_cycles == CYC_ONE) || step2;
   assign READY_O = (state == ST_IDLE) || last_step;
   assign take = START_I && READY_O && DECODE_HIT_O;
   assign is_indirect = (op == OP_DIR_IND) || (op == OP_IND_ACC) || (op == OP_IND_IMM);

   bbpmd_addr_map u_map (
      .bank_i(bank),
      .index_i(index_sel),
      .bit_addr_i(opr1),
      .index_addr_o(index_addr),
      .bit_byte_addr_o(bit_byte_addr),
      .bit_pos_o(bit_pos)
   );

   always_comb begin
      next_state = ST_IDLE;
      if (take) begin
         next_state = ST_STEP1;
      end else if (step1 && op_cycles == CYC_TWO) begin
         next_state = ST_STEP2;
      end
   end

   assign RD_EN_O = (step1 && (is_indirect || op == OP_C_BIT || op == OP_BIT_C))
                    || (step2 && op == OP_DIR_IND);
   assign RD_ADDR_O = (step2 && op == OP_DIR_IND) ? ind_ptr :
                      (step1 && is_indirect) ? index_addr :
                      RD_EN_O ? bit_byte_addr : 8'h00;

   // only the addressed bit is replaced
   assign bit_mask = BIT_ONE << bit_pos;
   assign bit_merged = (rmw_byte & ~bit_mask) | (carry_in ? bit_mask : 8'h00);

   // second step writes the indirect source to direct
   // direct address from byte two, constant from byte three
   assign next_wr_en = (step1 && (op == OP_DIR_IMM || op == OP_IND_ACC || op == OP_IND_IMM))
                       || (step2 && (op == OP_DIR_IND || op == OP_BIT_C));
   assign next_wr_addr = (step1 && (op == OP_IND_ACC || op == OP_IND_IMM)) ? RD_DATA_I :
                         (step2 && op == OP_BIT_C) ? bit_byte_addr : opr1;
   assign next_wr_data = (step1 && op == OP_DIR_IMM) ? opr2 :
                         (step1 && op == OP_IND_ACC) ? acc :
                         (step1 && op == OP_IND_IMM) ? opr1 :
                         (step2 && op == OP_BIT_C) ? bit_merged : RD_DATA_I;
   assign next_carry_we = step1 && (op == OP_C_BIT);
   assign next_carry_val = RD_DATA_I[bit_pos];

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state <= ST_IDLE;
         op <= OP_NONE;
         index_sel <= 1'b0;
         opr1 <= 8'h00;
         opr2 <= 8'h00;
         acc <= 8'h00;
         carry_in <= 1'b0;
         bank <= 2'h0;
      end else begin
         state <= next_state;
         if (take) begin
            op <= in_op;
            index_sel <= OPCODE_I[0];
            opr1 <= BYTE2_I;
            opr2 <= BYTE3_I;
            acc <= ACC_I;
            carry_in <= CARRY_I;
            bank <= BANK_I;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ind_ptr <= 8'h00;
         rmw_byte <= 8'h00;
      end else if (step1) begin
         ind_ptr <= RD_DATA_I;
         rmw_byte <= RD_DATA_I;
      end
   end

   // writes are registered and land one cycle after the step that made them
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         wr_en <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
         carry_we <= 1'b0;
         carry_val <= 1'b0;
      end else begin
         wr_en <= next_wr_en;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
         carry_we <= next_carry_we;
         carry_val <= next_carry_val;
      end
   end

   // whole pointer loaded in one edge
   // no flag strobe on this path
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         pointer_high_byte <= 8'h00;
         pointer_low_byte <= 8'h00;
      end else if (step1 && op == OP_PTR_LD) begin
         pointer_high_byte <= opr1;
         pointer_low_byte <= opr2;
      end
   end

   assign WR_EN_O = wr_en;
   assign WR_ADDR_O = wr_addr;
   assign WR_DATA_O = wr_data;
   assign CARRY_WE_O = carry_we;
   assign CARRY_O = carry_val;
   assign POINTER_O = {pointer_high_byte, pointer_low_byte};

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   a_dir_ind_move: assert property ((step2 && op == OP_DIR_IND) |=>
      (WR_EN_O && WR_ADDR_O == $past(opr1) && WR_DATA_O == $past(RD_DATA_I)))
      else $error("direct from indirect write wrong");
   a_dir_imm_write: assert property ((take && OPCODE_I == OPC_DIR_IMM) |=>
      !READY_O ##1 (READY_O && WR_EN_O && WR_ADDR_O == $past(BYTE2_I, 2)
      && WR_DATA_O == $past(BYTE3_I, 2)))
      else $error("direct immediate write wrong");
   a_carry_from_bit: assert property ((take && OPCODE_I == OPC_C_BIT) |=>
      READY_O ##1 (CARRY_WE_O && !WR_EN_O))
      else $error("carry load timing wrong");
   a_carry_value: assert property ((step1 && op == OP_C_BIT) |=>
      (CARRY_O == $past(RD_DATA_I[bit_pos])))
      else $error("carry value not the addressed bit");
   a_bit_from_carry: assert property ((step2 && op == OP_BIT_C) |=>
      (WR_EN_O && !CARRY_WE_O && ((WR_DATA_O ^ $past(rmw_byte)) & ~$past(bit_mask)) == 8'h00
      && WR_DATA_O[$past(bit_pos)] == $past(carry_in)))
      else $error("bit store touched other bits");
   a_bit_two_cycle: assert property ((take && OPCODE_I == OPC_BIT_C) |=>
      !READY_O ##1 READY_O ##1 WR_EN_O)
      else $error("bit store timing wrong");
   a_ptr_halves: assert property ((take && OPCODE_I == OPC_PTR_LD) |=>
      !READY_O ##1 (READY_O && POINTER_O == {$past(BYTE2_I, 2), $past(BYTE3_I, 2)}))
      else $error("pointer halves wrong");
   a_ptr_no_flags: assert property ((step1 && op == OP_PTR_LD) |=>
      (!CARRY_WE_O && !WR_EN_O))
      else $error("pointer load disturbed flags");
   a_index_select: assert property ((step1 && is_indirect) |->
      (RD_EN_O && RD_ADDR_O == {3'h0, bank, 2'h0, index_sel}))
      else $error("index register address wrong");
   a_ind_acc_store: assert property ((step1 && op == OP_IND_ACC) |=>
      (WR_EN_O && WR_ADDR_O == $past(RD_DATA_I) && WR_DATA_O == $past(acc)))
      else $error("accumulator store wrong");
   a_ind_imm_store: assert property ((take && (OPCODE_I & INDEX_MASK) == OPC_IND_IMM) |=>
      READY_O ##1 (WR_EN_O && WR_DATA_O == $past(BYTE2_I, 2)))
      else $error("indirect immediate store wrong");
endmodule // bbpmd_core

// ===== core/bbpmd_pkg.sv
// shared constants, types and decode functions for the byte/bit/pointer transfer_op unit
package bbpmd_pkg;

   // opcode patterns; the indirect forms carry the index bit in bit 0
   localparam logic [7:0] OPC_DIR_IND = 8'h86;
   localparam logic [7:0] OPC_DIR_IMM = 8'h75;
   localparam logic [7:0] OPC_IND_ACC = 8'hF6;
   localparam logic [7:0] OPC_IND_IMM = 8'h76;
   localparam logic [7:0] OPC_C_BIT = 8'hA2;
   localparam logic [7:0] OPC_BIT_C = 8'h92;
   localparam logic [7:0] OPC_PTR_LD = 8'h90;
   localparam logic [7:0] INDEX_MASK = 8'hFE;

   // bit space: low half maps into a byte area, upper half into byte-aligned registers
   localparam logic [7:0] BIT_AREA_BASE = 8'h20;
   localparam int BIT_SPLIT = 7;
   localparam logic [7:0] BIT_ONE = 8'h01;

   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;
   localparam logic [1:0] LEN_NONE = 2'h0;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;

   typedef enum logic [2:0] {
      OP_NONE, OP_DIR_IND, OP_DIR_IMM, OP_IND_ACC, OP_IND_IMM, OP_C_BIT, OP_BIT_C, OP_PTR_LD
   } bbpmd_op_t;

   typedef enum logic [1:0] {ST_IDLE, ST_STEP1, ST_STEP2} bbpmd_state_t;

   function automatic bbpmd_op_t bbpmd_decode(input logic [7:0] opc);
      bbpmd_op_t op;
      op = OP_NONE;
      if ((opc & INDEX_MASK) == OPC_DIR_IND) op = OP_DIR_IND;
      else if (opc == OPC_DIR_IMM) op = OP_DIR_IMM;
      else if ((opc & INDEX_MASK) == OPC_IND_ACC) op = OP_IND_ACC;
      else if ((opc & INDEX_MASK) == OPC_IND_IMM) op = OP_IND_IMM;
      else if (opc == OPC_C_BIT) op = OP_C_BIT;
      else if (opc == OPC_BIT_C) op = OP_BIT_C;
      else if (opc == OPC_PTR_LD) op = OP_PTR_LD;
      return op;
   endfunction

   function automatic logic [1:0] bbpmd_bytes(input bbpmd_op_t op);
      case (op)
         OP_IND_ACC: return LEN_ONE;
         OP_DIR_IND, OP_IND_IMM, OP_C_BIT, OP_BIT_C: return LEN_TWO;
         OP_DIR_IMM, OP_PTR_LD: return LEN_THREE;
         default: return LEN_NONE;
      endcase
   endfunction

   function automatic logic [1:0] bbpmd_cycles(input bbpmd_op_t op);
      case (op)
         OP_IND_ACC, OP_IND_IMM, OP_C_BIT: return CYC_ONE;
         default: return CYC_TWO;
      endcase
   endfunction

endpackage
